/* File: design/mic_remote_control.v */
// Overview of operation
// - sync pulses switch per channel; enabled channel lights its parameter led
// - phantom power off clears that channel's sync pulse enable
// - menu key enters menu lighting all eight leds; second press leaves
// - encoder steps options; with select held it steps that channel's value
// - every parameter change is saved to persistent store automatically
// - low cut codes 0..3 for off,40,80,160 hz, default off
// - pattern 0..15, default 0; 1 omni, 7 cardioid, 15 figure eight
// - pre-attenuation codes 0..3 for 0,-6,-12,-18 db, default 0
// - mute one bit, default off, sent to microphone as command
// - peak limiter one bit, default off
// - raw command bytes 1, 2, 4 each carry an editable eight-bit parameter
// - remote key picks aes, midi, madi or off; off ignores all commands
// - status request returns complete state including controls and leds
// - unit acts only on commands addressed to its programmable id
// - status replies leave on all outputs together, madi when fitted
// - incoming midi goes to processor and unchanged to midi output
// - link midi sits in user bit of channel 56, or 28 at 96k
// - link midi in goes to midi and link out; jack midi only if source midi
// - remote lock freezes panel except remote key; source off cancels it
`include "mic_remote_control_defines.vh"
`default_nettype none
module mic_remote_control (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// front panel
	input wire parameter_menu_key,
	input wire encoder_up,
	input wire encoder_down,
	input wire remote_key,
	input wire [7:0] select_key,
	input wire [7:0] digital_phantom_power,
	output reg [7:0] par_led,
	// remote byte streams
	input wire aes_rx_valid,
	input wire [7:0] aes_rx_data,
	input wire midi_rx_valid,
	input wire [7:0] midi_rx_data,
	input wire madi_rx_valid,
	input wire [7:0] madi_rx_data,
	input wire madi_fitted,
	input wire madi_frame96,
	input wire tx_ready,
	output reg midi_tx_valid,
	output reg [7:0] midi_tx_data,
	output reg madi_tx_valid,
	output reg [7:0] madi_tx_data,
	output reg [6:0] madi_midi_channel,
	// microphone control
	input wire [7:0] mic_slot,
	output wire [7:0] mic_cmd_valid,
	output wire [63:0] mic_cmd_byte,
	output wire [63:0] mic_par_byte,
	// persistent settings
	output reg save_strobe,
	output reg [5:0] save_index,
	output reg [7:0] save_data
);
	function [7:0] opt_mask;
		input [2:0] o;
		case (o)
			`OPT_LOWCUT: opt_mask = `MASK_2BIT;
			`OPT_PATTERN: opt_mask = `MASK_4BIT;
			`OPT_ATTEN: opt_mask = `MASK_2BIT;
			`OPT_MUTE: opt_mask = `MASK_1BIT;
			`OPT_LIMIT: opt_mask = `MASK_1BIT;
			default: opt_mask = `MASK_BYTE;
		endcase
	endfunction
	function [7:0] cmd_code;
		input [2:0] o;
		case (o)
			`OPT_LOWCUT: cmd_code = `MIC_CMD_LOWCUT;
			`OPT_PATTERN: cmd_code = `MIC_CMD_PATTERN;
			`OPT_ATTEN: cmd_code = `MIC_CMD_ATTEN;
			`OPT_MUTE: cmd_code = `MIC_CMD_MUTE;
			`OPT_LIMIT: cmd_code = `MIC_CMD_LIMIT;
			`OPT_RAW1: cmd_code = `MIC_CMD_RAW1;
			`OPT_RAW2: cmd_code = `MIC_CMD_RAW2;
			default: cmd_code = `MIC_CMD_RAW4;
		endcase
	endfunction

	reg [1:0] src_q;
	reg [1:0] src_d;
	reg lock_q;
	reg menu_q;
	reg [2:0] opt_q;
	reg [5:0] id_q;
	reg [7:0] sp_q;
	reg [7:0] sp_d;
	reg [7:0] cp_q;
	reg [7:0] cp_d;
	reg [7:0] par_q [0:63];
	reg ap_wr_q;
	reg [11:0] ap_addr_q;
	reg [1:0] cnt_q;
	reg hit_q;
	reg [7:0] op_q;
	reg [7:0] arg_q;
	reg stat_busy_q;
	reg [6:0] stat_idx_q;
	reg [7:0] stat_byte;
	reg [31:0] rd_d;
	reg sel_found;
	reg [2:0] sel_ch;
	reg pw_en;
	reg [5:0] pw_idx;
	reg [7:0] pw_val;
	reg [7:0] cur;
	reg rx_v;
	reg [7:0] rx_d;
	integer i;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	wire unlocked = ~lock_q;
	wire bus_wr = ap_wr_q;
	wire bus_pw = bus_wr && (ap_addr_q[11:8] == `PARAM_PAGE);
	wire enc_step = encoder_up ^ encoder_down;
	wire panel_edit = unlocked && menu_q && sel_found && enc_step;

	// lowest held select key names the channel being edited
	always @* begin
		sel_found = 1'b0;
		sel_ch = 3'h0;
		for (i = 7; i >= 0; i = i - 1) begin
			if (select_key[i]) begin
				sel_found = 1'b1;
				sel_ch = i[2:0];
			end
		end
	end

	// remote source selection; off passes nothing through to the parser
	always @* begin
		case (src_q)
			`SRC_AES: begin
				rx_v = aes_rx_valid;
				rx_d = aes_rx_data;
			end
			`SRC_MIDI: begin
				rx_v = midi_rx_valid;
				rx_d = midi_rx_data;
			end
			`SRC_MADI: begin
				rx_v = madi_rx_valid;
				rx_d = madi_rx_data;
			end
			default: begin
				rx_v = 1'b0;
				rx_d = 8'h00;
			end
		endcase
	end

	// frame: start byte (bit7 set, id), opcode, arg {v7,ch,opt}, value
	wire exec = rx_v && !rx_d[7] && (cnt_q == 2'h3) && hit_q;
	wire rc_set = exec && (op_q == `OP_SET);
	wire rc_status = exec && (op_q == `OP_STATUS);
	wire [7:0] rc_val = {arg_q[6], rx_d[6:0]};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 2'h0;
			hit_q <= 1'b0;
			op_q <= 8'h00;
			arg_q <= 8'h00;
		end else if (rx_v) begin
			if (rx_d[7]) begin
				cnt_q <= 2'h1;
				hit_q <= (rx_d[5:0] == id_q);
			end else begin
				case (cnt_q)
					2'h1: begin
						op_q <= rx_d;
						cnt_q <= 2'h2;
					end
					2'h2: begin
						arg_q <= rx_d;
						cnt_q <= 2'h3;
					end
					2'h3: cnt_q <= 2'h0;
					default: cnt_q <= 2'h0;
				endcase
			end
		end
	end

	// single parameter write port: bus, then remote, then panel
	always @* begin
		pw_en = 1'b0;
		pw_idx = 6'h00;
		pw_val = 8'h00;
		cur = 8'h00;
		if (bus_pw) begin
			pw_en = 1'b1;
			pw_idx = ap_addr_q[7:2];
			pw_val = hwdata[7:0] & opt_mask(ap_addr_q[4:2]);
		end else if (rc_set) begin
			pw_en = 1'b1;
			pw_idx = arg_q[5:0];
			pw_val = rc_val & opt_mask(arg_q[2:0]);
		end else if (panel_edit) begin
			pw_en = 1'b1;
			pw_idx = {sel_ch, opt_q};
			cur = par_q[{sel_ch, opt_q}];
			pw_val = (encoder_up ? cur + 8'h01 : cur - 8'h01) & opt_mask(opt_q);
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (i = 0; i < 64; i = i + 1) begin
				par_q[i] <= `RST_PARAM;
			end
			save_strobe <= 1'b0;
			save_index <= 6'h00;
			save_data <= 8'h00;
		end else begin
			save_strobe <= pw_en;
			if (pw_en) begin
				par_q[pw_idx] <= pw_val;
				save_index <= pw_idx;
				save_data <= pw_val;
			end
		end
	end

	// source, lock, menu, option, id, pulse enables
	always @* begin
		src_d = src_q;
		if (bus_wr && ap_addr_q == `REG_CTRL) begin
			src_d = hwdata[1:0];
		end else if (remote_key) begin
			src_d = src_q + 2'h1;
		end
		sp_d = sp_q;
		if (bus_wr && ap_addr_q == `REG_SYNC) begin
			sp_d = hwdata[7:0];
		end else if (exec && op_q == `OP_SYNC) begin
			sp_d = rc_val;
		end
		cp_d = cp_q;
		if (bus_wr && ap_addr_q == `REG_CTLP) begin
			cp_d = hwdata[7:0];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_q <= `RST_SOURCE;
			lock_q <= 1'b0;
			menu_q <= 1'b0;
			opt_q <= `OPT_LOWCUT;
			id_q <= `RST_ID;
			sp_q <= `RST_SYNC;
			cp_q <= `RST_CTLP;
			par_led <= 8'h00;
			madi_midi_channel <= `MADI_CH_48K;
		end else begin
			src_q <= src_d;
			if (src_d == `SRC_OFF) begin
				lock_q <= 1'b0;
			end else if (exec && op_q == `OP_LOCK) begin
				lock_q <= 1'b1;
			end else if (exec && op_q == `OP_UNLOCK) begin
				lock_q <= 1'b0;
			end
			if (unlocked && parameter_menu_key) begin
				menu_q <= ~menu_q;
			end
			if (unlocked && menu_q && !sel_found && enc_step) begin
				opt_q <= encoder_up ? opt_q + 3'h1 : opt_q - 3'h1;
			end
			if (bus_wr && ap_addr_q == `REG_ID) begin
				id_q <= hwdata[5:0];
			end
			sp_q <= sp_d & digital_phantom_power;
			cp_q <= cp_d & digital_phantom_power;
			par_led <= menu_q ? 8'hFF : sp_q;
			madi_midi_channel <= madi_frame96 ? `MADI_CH_96K : `MADI_CH_48K;
		end
	end

	// status reply: eight header bytes then all 64 parameter bytes
	wire [6:0] stat_off = stat_idx_q - `STAT_HDR;
	always @* begin
		case (stat_idx_q)
			7'h00: stat_byte = {2'h0, id_q};
			7'h01: stat_byte = {1'b0, opt_q, menu_q, lock_q, src_q};
			7'h02: stat_byte = sp_q;
			7'h03: stat_byte = cp_q;
			7'h04: stat_byte = par_led;
			7'h05: stat_byte = digital_phantom_power;
			7'h06: stat_byte = select_key;
			7'h07: stat_byte = {6'h00, madi_fitted, madi_frame96};
			default: stat_byte = par_q[stat_off[5:0]];
		endcase
	end

	wire stat_go = stat_busy_q && tx_ready && !midi_rx_valid && !madi_rx_valid;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_busy_q <= 1'b0;
			stat_idx_q <= 7'h00;
			midi_tx_valid <= 1'b0;
			midi_tx_data <= 8'h00;
			madi_tx_valid <= 1'b0;
			madi_tx_data <= 8'h00;
		end else begin
			if (!stat_busy_q && rc_status) begin
				stat_busy_q <= 1'b1;
				stat_idx_q <= 7'h00;
			end else if (stat_go) begin
				stat_idx_q <= stat_idx_q + 7'h01;
				if (stat_idx_q == `STAT_LAST) begin
					stat_busy_q <= 1'b0;
				end
			end
			midi_tx_valid <= midi_rx_valid || madi_rx_valid || stat_go;
			if (midi_rx_valid) begin
				midi_tx_data <= midi_rx_data;
			end else if (madi_rx_valid) begin
				midi_tx_data <= madi_rx_data;
			end else if (stat_go) begin
				midi_tx_data <= stat_byte;
			end
			madi_tx_valid <= madi_rx_valid || (midi_rx_valid && src_q == `SRC_MIDI) || (stat_go && madi_fitted);
			if (madi_rx_valid) begin
				madi_tx_data <= madi_rx_data;
			end else if (midi_rx_valid && src_q == `SRC_MIDI) begin
				madi_tx_data <= midi_rx_data;
			end else if (stat_go) begin
				madi_tx_data <= stat_byte;
			end
		end
	end

	// per-channel pending command toward the microphone
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : chan
			localparam [2:0] CH = g;
			reg pend_q;
			reg [2:0] popt_q;
			reg valid_q;
			reg [7:0] cmd_q;
			reg [7:0] val_q;
			wire fire = pend_q && mic_slot[g] && cp_q[g];
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pend_q <= 1'b0;
					popt_q <= 3'h0;
					valid_q <= 1'b0;
					cmd_q <= 8'h00;
					val_q <= 8'h00;
				end else begin
					valid_q <= fire;
					if (fire) begin
						cmd_q <= cmd_code(popt_q);
						val_q <= par_q[{CH, popt_q}];
					end
					if (pw_en && pw_idx[5:3] == CH) begin
						pend_q <= 1'b1;
						popt_q <= pw_idx[2:0];
					end else if (fire) begin
						pend_q <= 1'b0;
					end
				end
			end
			assign mic_cmd_valid[g] = valid_q;
			assign mic_cmd_byte[8*g+7:8*g] = cmd_q;
			assign mic_par_byte[8*g+7:8*g] = val_q;
		end
	endgenerate

	// ahb-lite: zero wait states, read data registered in the address phase
	always @* begin
		rd_d = 32'h00000000;
		if (haddr[11:8] == `PARAM_PAGE) begin
			rd_d = {24'h000000, par_q[haddr[7:2]]};
		end else begin
			case (haddr)
				`REG_CTRL: rd_d = {25'h0000000, opt_q, menu_q, lock_q, src_q};
				`REG_ID: rd_d = {26'h0000000, id_q};
				`REG_SYNC: rd_d = {24'h000000, sp_q};
				`REG_CTLP: rd_d = {24'h000000, cp_q};
				`REG_PANEL: rd_d = {8'h00, select_key, digital_phantom_power, par_led};
				default: rd_d = 32'h00000000;
			endcase
		end
	end

	wire ap_take = hsel && htrans[1] && hready;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= 12'h000;
			hrdata <= 32'h00000000;
		end else begin
			ap_wr_q <= ap_take && hwrite;
			if (ap_take) begin
				ap_addr_q <= {haddr[11:2], 2'h0};
			end
			hrdata <= (ap_take && !hwrite) ? rd_d : 32'h00000000;
		end
	end
endmodule // mic_remote_control
`default_nettype wire

/* File: design/mic_remote_control_defines.vh */
`ifndef MIC_REMOTE_CONTROL_DEFINES_VH
`define MIC_REMOTE_CONTROL_DEFINES_VH
// register byte offsets
`define REG_CTRL 12'h000
`define REG_ID 12'h004
`define REG_SYNC 12'h008
`define REG_CTLP 12'h00C
`define REG_PANEL 12'h010
`define PARAM_PAGE 4'h1
// reset values
`define RST_SOURCE 2'h2
`define RST_ID 6'h01
`define RST_SYNC 8'hFF
`define RST_CTLP 8'hFF
`define RST_PARAM 8'h00
// remote sources
`define SRC_OFF 2'h0
`define SRC_AES 2'h1
`define SRC_MIDI 2'h2
`define SRC_MADI 2'h3
// menu options and their value masks
`define OPT_LOWCUT 3'h0
`define OPT_PATTERN 3'h1
`define OPT_ATTEN 3'h2
`define OPT_MUTE 3'h3
`define OPT_LIMIT 3'h4
`define OPT_RAW1 3'h5
`define OPT_RAW2 3'h6
`define OPT_RAW4 3'h7
`define MASK_2BIT 8'h03
`define MASK_4BIT 8'h0F
`define MASK_1BIT 8'h01
`define MASK_BYTE 8'hFF
// microphone command bytes
`define MIC_CMD_LOWCUT 8'h10
`define MIC_CMD_PATTERN 8'h11
`define MIC_CMD_ATTEN 8'h12
`define MIC_CMD_MUTE 8'h13
`define MIC_CMD_LIMIT 8'h14
`define MIC_CMD_RAW1 8'h01
`define MIC_CMD_RAW2 8'h02
`define MIC_CMD_RAW4 8'h04
// remote command opcodes
`define OP_SET 8'h01
`define OP_STATUS 8'h02
`define OP_LOCK 8'h03
`define OP_UNLOCK 8'h04
`define OP_SYNC 8'h05
// status reply length minus one, header bytes
`define STAT_LAST 7'h47
`define STAT_HDR 7'h08
// user bit channel carrying midi on the optical/coax link
`define MADI_CH_48K 7'h38
`define MADI_CH_96K 7'h1C
`endif

/* File: verification/mic_remote_control_assertions.sv */
`default_nettype none
module mic_remote_control_chk (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// panel
	input wire logic [7:0] digital_phantom_power,
	input wire logic [7:0] par_led,
	// byte streams
	input wire logic midi_rx_valid,
	input wire logic [7:0] midi_rx_data,
	input wire logic madi_rx_valid,
	input wire logic [7:0] madi_rx_data,
	input wire logic madi_fitted,
	input wire logic madi_frame96,
	input wire logic midi_tx_valid,
	input wire logic [7:0] midi_tx_data,
	input wire logic madi_tx_valid,
	input wire logic [7:0] madi_tx_data,
	input wire logic [6:0] madi_midi_channel,
	// microphone and store
	input wire logic [7:0] mic_slot,
	input wire logic [7:0] mic_cmd_valid,
	input wire logic save_strobe,
	input wire logic [5:0] save_index,
	input wire logic [7:0] save_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_dpp_steady;
		$stable(digital_phantom_power) [*3];
	endsequence
	property p_led_sync;
		s_dpp_steady ##0 (par_led != 8'hFF) |-> (par_led & ~digital_phantom_power) == 8'h00;
	endproperty
	property p_midi_thru;
		midi_rx_valid |=> midi_tx_valid && midi_tx_data == $past(midi_rx_data);
	endproperty
	property p_madi_thru;
		madi_rx_valid |=> madi_tx_valid && madi_tx_data == $past(madi_rx_data);
	endproperty
	property p_link_channel;
		1'b1 |=> madi_midi_channel == ($past(madi_frame96) ? 7'h1C : 7'h38);
	endproperty
	property p_status_both;
		midi_tx_valid && $past(madi_fitted) && !$past(midi_rx_valid) && !$past(madi_rx_valid)
			|-> madi_tx_valid && madi_tx_data == midi_tx_data;
	endproperty
	property p_mic_slot;
		|mic_cmd_valid |-> (mic_cmd_valid & ~$past(mic_slot)) == 8'h00;
	endproperty
	property p_two_bit;
		save_strobe && (save_index[2:0] == 3'h0 || save_index[2:0] == 3'h2) |-> save_data <= 8'h03;
	endproperty
	property p_pattern;
		save_strobe && save_index[2:0] == 3'h1 |-> save_data <= 8'h0F;
	endproperty
	property p_one_bit;
		save_strobe && (save_index[2:0] == 3'h3 || save_index[2:0] == 3'h4) |-> save_data <= 8'h01;
	endproperty
	a_led_sync: assert property (p_led_sync) else $error("led lit on unpowered channel");
	a_midi_thru: assert property (p_midi_thru) else $error("midi byte not passed through");
	a_madi_thru: assert property (p_madi_thru) else $error("link byte not passed on");
	a_link_channel: assert property (p_link_channel) else $error("wrong link user bit channel");
	a_status_both: assert property (p_status_both) else $error("reply not on both outputs");
	a_mic_slot: assert property (p_mic_slot) else $error("mic command outside its slot");
	a_two_bit: assert property (p_two_bit) else $error("two bit code out of range");
	a_pattern: assert property (p_pattern) else $error("pattern out of range");
	a_one_bit: assert property (p_one_bit) else $error("one bit setting out of range");
endmodule // mic_remote_control_chk
bind mic_remote_control mic_remote_control_chk i_chk (.hclk(hclk), .hresetn(hresetn),
	.digital_phantom_power(digital_phantom_power), .par_led(par_led), .midi_rx_valid(midi_rx_valid),
	.midi_rx_data(midi_rx_data), .madi_rx_valid(madi_rx_valid), .madi_rx_data(madi_rx_data),
	.madi_fitted(madi_fitted), .madi_frame96(madi_frame96), .midi_tx_valid(midi_tx_valid),
	.midi_tx_data(midi_tx_data), .madi_tx_valid(madi_tx_valid), .madi_tx_data(madi_tx_data),
	.madi_midi_channel(madi_midi_channel), .mic_slot(mic_slot), .mic_cmd_valid(mic_cmd_valid),
	.save_strobe(save_strobe), .save_index(save_index), .save_data(save_data));
`default_nettype wire

/* File: verification/mic_remote_host.sv */
`default_nettype none
module mic_remote_host (
	// clock
	input wire logic hclk,
	// midi towards the block
	output logic midi_rx_valid,
	output logic [7:0] midi_rx_data
);
	timeunit 1ns;
	timeprecision 1ps;
	int gap = 0;
	initial begin
		midi_rx_valid = 1'b0;
		midi_rx_data = 8'h00;
	end
	// one frame: addressed header, opcode, argument, value
	task automatic send(input logic [5:0] id, input logic [7:0] op, arg, val);
		logic [7:0] b [4];
		b = '{8'h80 | {2'h0, id}, op, arg, val};
		foreach (b[i]) begin
			midi_rx_valid <= 1'b1;
			midi_rx_data <= b[i];
			@(posedge hclk);
			midi_rx_valid <= 1'b0;
			// idle line shows no stale byte
			midi_rx_data <= ~b[i];
			repeat (gap + 1) @(posedge hclk);
		end
	endtask
endmodule // mic_remote_host
`default_nettype wire

/* File: verification/mic_remote_control_tb_top.sv */
`include "mic_remote_control_defines.vh"
`default_nettype none
module mic_remote_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp, rd_dp = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic [3:0] keys = 4'h0;
	logic parameter_menu_key, encoder_up, encoder_down, remote_key, midi_rx_valid, midi_tx_valid, madi_tx_valid;
	logic madi_fitted = 1'b1, madi_frame96 = 1'b0, madi_rx_valid = 1'b0, save_strobe;
	logic [7:0] select_key = 8'h00, digital_phantom_power = 8'hFF, mic_slot = 8'h00, madi_rx_data = 8'h00;
	logic [7:0] par_led, midi_rx_data, midi_tx_data, madi_tx_data, mic_cmd_valid, save_data;
	logic [63:0] mic_cmd_byte, mic_par_byte;
	logic [5:0] save_index;
	logic [7:0] par_m [64];
	logic [31:0] qr [$], qm [$], qs [$], qc [$], tail [$];
	int n_errors = 0, total_checks = 0, cyc = 0;
	localparam logic [7:0] msk [8] = '{8'h03, 8'h0F, 8'h03, 8'h01, 8'h01, 8'hFF, 8'hFF, 8'hFF};
	assign hready = hreadyout;
	assign {remote_key, encoder_down, encoder_up, parameter_menu_key} = keys;
	mic_remote_control i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
		.hresp, .hrdata, .parameter_menu_key, .encoder_up, .encoder_down, .remote_key, .select_key,
		// aes input mirrors the link bytes so that either source can be exercised
		.digital_phantom_power, .par_led, .aes_rx_valid(madi_rx_valid), .aes_rx_data(madi_rx_data),
		.midi_rx_valid, .midi_rx_data,
		.madi_rx_valid, .madi_rx_data, .madi_fitted, .madi_frame96, .tx_ready(1'b1), .midi_tx_valid, .midi_tx_data,
		.madi_tx_valid, .madi_tx_data, .madi_midi_channel(), .mic_slot, .mic_cmd_valid, .mic_cmd_byte,
		.mic_par_byte, .save_strobe, .save_index, .save_data);
	mic_remote_host i_host (.hclk, .midi_rx_valid, .midi_rx_data);
	always #20 hclk = ~hclk;
	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] take(ref logic [31:0] q [$]);
		return q.size() != 0 ? q.pop_front() : 'x;
	endfunction
	task automatic final_report();
		chk(32'(qm.size() + qs.size() + qc.size()), 32'h0);
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// watcher: every result takes the oldest note of its kind
	always @(posedge hclk) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			final_report();
		end
		if (rd_dp) chk(hrdata, take(qr));
		if (hresetn && midi_tx_valid !== 1'b0) chk({24'h0, midi_tx_data}, take(qm));
		if (hresetn && save_strobe !== 1'b0) chk({18'h0, save_index, save_data}, take(qs));
		if (hresetn && mic_cmd_valid !== 8'h00)
			chk({8'h0, mic_cmd_valid, mic_cmd_byte[31:24], mic_par_byte[31:24]}, take(qc));
	end
	task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_dp <= !w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		qr.push_back(e);
		ahb(a, 1'b0, 32'h0);
	endtask
	task automatic remote(input logic [5:0] id, input logic [7:0] op, arg, val);
		qm.push_back({26'h0, id} | 32'h80);
		qm.push_back({24'h0, op});
		qm.push_back({24'h0, arg});
		qm.push_back({24'h0, val});
		qm = {qm, tail};
		tail = {};
		i_host.send(id, op, arg, val);
	endtask
	task automatic set_par(input logic [5:0] id, input logic [2:0] ch, opt, input logic [7:0] v, input bit ok);
		logic [7:0] e;
		e = v & msk[opt];
		if (ok) begin
			par_m[{ch, opt}] = e;
			qs.push_back({18'h0, ch, opt, e});
		end
		remote(id, `OP_SET, {1'b0, v[7], ch, opt}, {1'b0, v[6:0]});
	endtask
	task automatic press(input int k);
		keys <= 4'h1 << k;
		@(posedge hclk);
		keys <= 4'h0;
		repeat (3) @(posedge hclk);
	endtask
	task automatic slot3();
		mic_slot <= 8'h08;
		@(posedge hclk);
		mic_slot <= 8'h00;
		repeat (3) @(posedge hclk);
	endtask
	// one byte on the link input; it must come back on the midi output
	task automatic madi_send(input logic [7:0] b);
		qm.push_back({24'h0, b});
		madi_rx_valid <= 1'b1;
		madi_rx_data <= b;
		@(posedge hclk);
		madi_rx_valid <= 1'b0;
		madi_rx_data <= ~b;
		@(posedge hclk);
	endtask
	task automatic madi_frame(input logic [5:0] id, input logic [7:0] op, arg, val);
		madi_send({2'h2, id});
		madi_send(op);
		madi_send(arg);
		madi_send(val);
	endtask
	initial begin
		void'($urandom(32'hF0D6745D));
		foreach (par_m[i]) par_m[i] = 8'h00;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`REG_CTRL, 32'h2);
		rd(`REG_SYNC, 32'hFF);
		rd(`REG_ID, 32'h1);
		rd(`REG_CTLP, 32'hFF);
		rd(12'h020, 32'h0);
		for (int o = 0; o < 8; o++) rd(12'(12'h1E0 + 4 * o), 32'h0);
		for (int o = 0; o < 8; o++) begin
			i_host.gap = o % 3;
			set_par(6'h01, 3'h5, 3'(o), 8'($urandom), 1'b1);
		end
		set_par(6'h02, 3'h5, 3'h1, 8'h05, 1'b0);
		qc.push_back({16'h0008, `MIC_CMD_PATTERN, 8'h09});
		set_par(6'h01, 3'h3, 3'h1, 8'h09, 1'b1);
		slot3();
		ahb(`REG_CTLP, 1'b1, 32'hF7);
		set_par(6'h01, 3'h3, 3'h2, 8'h02, 1'b1);
		slot3();
		i_host.gap = 0;
		tail = '{32'h01, 32'h02, 32'hFF, 32'hF7, 32'hFF, 32'hFF, 32'h00, 32'h02};
		foreach (par_m[i]) tail.push_back({24'h0, par_m[i]});
		remote(6'h01, `OP_STATUS, 8'h00, 8'h00);
		while (qm.size() != 0) @(posedge hclk);
		madi_frame96 <= 1'b1;
		for (int i = 0; i < 4; i++) madi_send(8'($urandom));
		digital_phantom_power <= 8'h0F;
		repeat (4) @(posedge hclk);
		chk({24'h0, par_led}, 32'h0F);
		press(0);
		chk({24'h0, par_led}, 32'hFF);
		press(1);
		select_key <= 8'h06;
		qs.push_back({18'h0, 3'h1, 3'h1, 8'h0F});
		press(2);
		remote(6'h01, `OP_LOCK, 8'h00, 8'h00);
		press(2);
		press(3);
		press(3);
		set_par(6'h01, 3'h5, 3'h0, 8'h01, 1'b0);
		qs.push_back({18'h0, 3'h1, 3'h1, 8'h0E});
		press(2);
		select_key <= 8'h00;
		press(0);
		chk({24'h0, par_led}, 32'h0F);
		// new id, then frames over the aes and link sources
		ahb(`REG_ID, 1'b1, 32'h2A);
		ahb(`REG_CTRL, 1'b1, 32'h1);
		madi_frame(6'h2A, `OP_LOCK, 8'h00, 8'h00);
		rd(`REG_CTRL, 32'h15);
		ahb(`REG_CTRL, 1'b1, 32'h3);
		madi_frame(6'h01, `OP_UNLOCK, 8'h00, 8'h00);
		rd(`REG_CTRL, 32'h17);
		madi_frame(6'h2A, `OP_UNLOCK, 8'h00, 8'h00);
		madi_frame(6'h2A, `OP_SYNC, 8'h40, 8'h35);
		rd(`REG_CTRL, 32'h13);
		rd(`REG_SYNC, 32'h05);
		rd(`REG_PANEL, 32'h00000F05);
		repeat (8) @(posedge hclk);
		final_report();
	end
endmodule // mic_remote_control_tb_top
`default_nettype wire
